// ==== cpc_pkg.sv ====
// Shared constants, register map and carrier types for the charge controller
// Operation
// - Start system after 200us good-input immunity time
// - Input outside window turns input switch off
// - Below precharge threshold, precharge at selected current
// - One hour precharge without progress stops, faults
// - Above precharge threshold, fast charge selected current
// - At charge-full voltage move to constant voltage
// - Termination enabled: 2.5ms qualified delay marks done
// - Timer mode zero cuts current, one keeps tapering
// - Termination disabled never detects or marks done
// - New cycle on recycle, enable, recharge; faults block
// - After done, low battery restarts charging automatically
// - Auto recharge needs termination on, mode zero
// - Battery over-voltage suspends charging, raises fault
// - Input limit and minimum system voltage reduce charge
// - Supplement on 30mV below, off 20mV above
// - No input: discharge mode, battery switch on
// - Die temperature limit reached reduces charge current
// - Die at 150C turns both switches off
// - Cycle start, enable or high-z toggle reset timers
package cpc_pkg;
  // Clock and timing figures
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned IMM_TIME_NS = 200000;
  localparam int unsigned TERM_TIME_NS = 2500000;
  localparam int unsigned TICK_TIME_NS = 1000000;
  localparam int unsigned PRE_TIME_S = 3600;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned IMM_CYCLES_DEF = IMM_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TERM_CYCLES_DEF = TERM_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned PRE_TICKS_DEF = PRE_TIME_S * MS_PER_S;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CUR = 8'h04;
  localparam logic [7:0] REG_VOLT = 8'h08;
  localparam logic [7:0] REG_TERM = 8'h0c;
  localparam logic [7:0] REG_THERM = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_FAULT = 8'h18;
  // Field positions
  localparam int CTRL_CHG_EN = 0;
  localparam int CTRL_HIZ = 1;
  localparam int CTRL_FORCE_OFF = 2;
  localparam int TERM_MODE_BIT = 0;
  localparam int TERM_EN_BIT = 6;
  localparam int FLT_SAFETY = 0;
  localparam int FLT_BOVP = 1;
  localparam int FLT_INPUT = 2;
  localparam int FLT_THERM = 3;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] CUR_RST = 32'h0000_0108;
  localparam logic [31:0] VOLT_RST = 32'h0000_0080;
  localparam logic [31:0] TERM_RST = 32'h0000_0040;
  localparam logic [31:0] THERM_RST = 32'h0000_0003;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Charge phases as reported
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000, PH_PRE = 3'b001, PH_FAST = 3'b010,
    PH_CV = 3'b011, PH_DONE = 3'b100
  } cpc_phase_t;
  // Input qualification states
  typedef enum logic [1:0] {
    IN_OFF = 2'b00, IN_WAIT = 2'b01, IN_ON = 2'b10
  } cpc_in_t;
  // Comparator flags from the analog side
  typedef struct packed {
    logic vin_present;      // Some input voltage seen
    logic vin_good;         // Input inside over/under-voltage window
    logic vbatt_above_pre;  // Battery above precharge threshold
    logic vbatt_at_full;    // Battery at charge-full voltage
    logic vbatt_ovp;        // Battery about 130mV over full voltage
    logic vbatt_below_rech; // Battery below recharge threshold
    logic ichg_at_term;     // Charge current at end_of_charge_current
    logic ibatt_above_hys;  // Current above end-of-charge plus hysteresis
    logic dpm_limit;        // Input current or voltage limit reached
    logic vsys_at_min;      // System voltage at its minimum
    logic vsys_below_30;    // System 30mV below battery
    logic vsys_above_20;    // System 20mV above battery
    logic tj_at_reg;        // Die at regulation limit
    logic tj_shutdown;      // Die at 150C
    logic ntc_fault;        // Thermistor fault
  } cpc_sense_t;
  // Switch and loop controls to the analog side
  typedef struct packed {
    logic input_pass_switch;  // Input pass switch on
    logic battery_switch;     // Battery switch fully on
    logic charge_on;          // Charge current source on
    logic precharge_mode;     // Precharge current in use
    logic cv_mode;            // Constant-voltage loop in use
    logic charge_reduce;      // Lower charge current
    logic supplement_mode;    // Ideal-diode supplement on
    logic [1:0] prechg_sel;   // Precharge current code
    logic [4:0] fast_sel;     // Fast charge current code
    logic [5:0] full_sel;     // Charge-full voltage code
    logic [1:0] die_temp_regulation_limit; // Regulation limit code
  } cpc_drive_t;
endpackage

// ==== cpc_charge_phase_controller.sv ====
// Charge phase controller with AXI4-Lite register slave
`timescale 1ns/1ps
module cpc_charge_phase_controller import cpc_pkg::*; #(
  parameter int unsigned IMM_CYCLES = IMM_CYCLES_DEF,
  parameter int unsigned TERM_CYCLES = TERM_CYCLES_DEF,
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int unsigned PRE_TICKS = PRE_TICKS_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cpc_sense_t sense_pins,
  output cpc_drive_t drive
);
  // Map an address to a register slot, 7 means unmapped
  function automatic logic [2:0] reg_slot(input logic [7:0] a);
    case (a)
      REG_CTRL: reg_slot = 3'h0;
      REG_CUR: reg_slot = 3'h1;
      REG_VOLT: reg_slot = 3'h2;
      REG_TERM: reg_slot = 3'h3;
      REG_THERM: reg_slot = 3'h4;
      REG_STATUS: reg_slot = 3'h5;
      REG_FAULT: reg_slot = 3'h6;
      default: reg_slot = 3'h7;
    endcase
  endfunction

  // Merge write data into a register by byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] st);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  cpc_sense_t sense_m_q; // First synchroniser stage
  cpc_sense_t s_q; // Synchronised comparator flags
  logic [31:0] ctrl_q, cur_q, volt_q, term_q, therm_q; // Config regs
  logic [3:0] fault_q; // Sticky fault flags
  logic [7:0] awaddr_q; // Held write address
  logic aw_full_q; // Write address held
  logic [31:0] wdata_q; // Held write data
  logic [3:0] wstrb_q; // Held write strobes
  logic w_full_q; // Write data held
  logic wr_go; // Write performed this cycle
  logic [2:0] wr_slot; // Target slot of the write
  logic [31:0] fault_clr; // Write-one-to-clear mask for faults
  logic [31:0] status_word; // Live status readback
  cpc_in_t in_q; // Input qualification state
  logic [31:0] imm_cnt_q; // Immunity timer
  logic recycle; // Input just qualified
  cpc_phase_t phase_q; // Charge phase
  logic [31:0] tick_cnt_q; // Millisecond divider
  logic tick; // One-cycle millisecond enable
  logic [31:0] pre_cnt_q; // Precharge timer in ticks
  logic pre_expire; // Precharge time ran out
  logic term_run_q; // Termination delay running
  logic [31:0] term_cnt_q; // Termination delay counter
  logic term_done; // Termination delay qualified
  logic chg_en_prev_q, hiz_prev_q; // Previous control bits
  logic chg_toggle, hiz_toggle, timer_rst; // Timer reset events
  logic en_term, term_mode, chg_en, hiz, force_off; // Config bits
  logic input_on; // Input qualified and in window
  logic allowed; // Charging may proceed
  logic no_block; // No fault blocks a new cycle
  logic rech_evt; // Auto recharge request
  logic start_evt; // New charge cycle begins
  logic supp_q; // Supplement mode state
  logic charging; // Current source demanded

  assign chg_en = ctrl_q[CTRL_CHG_EN];
  assign hiz = ctrl_q[CTRL_HIZ];
  assign force_off = ctrl_q[CTRL_FORCE_OFF];
  assign en_term = term_q[TERM_EN_BIT];
  assign term_mode = term_q[TERM_MODE_BIT];

  // Two-stage synchroniser for the comparator flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_m_q <= '0;
      s_q <= '0;
    end else begin
      sense_m_q <= sense_pins;
      s_q <= sense_m_q;
    end
  end

  // AXI write channel capture, address and data in either order
  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = !w_full_q && !s_axi_bvalid;
  assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_slot = reg_slot(awaddr_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        // Status is read-only; unmapped answers with an error
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_slot > 3'h4 && wr_slot != 3'h6) ?
                       RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      cur_q <= CUR_RST;
      volt_q <= VOLT_RST;
      term_q <= TERM_RST;
      therm_q <= THERM_RST;
    end else if (wr_go) begin
      case (wr_slot)
        3'h0: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
        3'h1: cur_q <= merge(cur_q, wdata_q, wstrb_q);
        3'h2: volt_q <= merge(volt_q, wdata_q, wstrb_q);
        3'h3: term_q <= merge(term_q, wdata_q, wstrb_q);
        3'h4: therm_q <= merge(therm_q, wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // Read channel, data registered at address acceptance
  assign s_axi_arready = !s_axi_rvalid;
  assign status_word = {24'h0, supp_q, drive.charge_reduce,
                        (in_q == IN_ON), s_q.vin_good, term_run_q,
                        phase_q};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (reg_slot(s_axi_araddr))
        3'h0: s_axi_rdata <= ctrl_q;
        3'h1: s_axi_rdata <= cur_q;
        3'h2: s_axi_rdata <= volt_q;
        3'h3: s_axi_rdata <= term_q;
        3'h4: s_axi_rdata <= therm_q;
        3'h5: s_axi_rdata <= status_word;
        3'h6: s_axi_rdata <= {28'h0, fault_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Input qualification with immunity timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_q <= IN_OFF;
      imm_cnt_q <= 32'h0000_0000;
    end else begin
      case (in_q)
        IN_OFF: begin
          imm_cnt_q <= 32'h0000_0000;
          if (s_q.vin_good) begin
            in_q <= IN_WAIT;
          end
        end
        IN_WAIT: begin
          if (!s_q.vin_good) begin
            in_q <= IN_OFF;
          end else if (imm_cnt_q == IMM_CYCLES - 1) begin
            in_q <= IN_ON;
          end else begin
            imm_cnt_q <= imm_cnt_q + 32'h0000_0001;
          end
        end
        IN_ON: begin
          imm_cnt_q <= 32'h0000_0000; // Expiry mark lasts one cycle
          if (!s_q.vin_good) begin
            in_q <= IN_OFF;
          end
        end
        default: in_q <= IN_OFF;
      endcase
    end
  end
  assign recycle = (in_q == IN_ON) && s_q.vin_good &&
                   (imm_cnt_q == IMM_CYCLES - 1);
  assign input_on = (in_q == IN_ON) && s_q.vin_good;

  // Cycle start and timer reset events
  assign chg_toggle = chg_en != chg_en_prev_q;
  assign hiz_toggle = hiz != hiz_prev_q;
  assign allowed = input_on && chg_en && !hiz && !force_off &&
                   !s_q.ntc_fault && !s_q.tj_shutdown;
  assign no_block = !s_q.ntc_fault && !fault_q[FLT_SAFETY] &&
                    !s_q.vbatt_ovp && !force_off;
  assign rech_evt = (phase_q == PH_DONE) && en_term && !term_mode &&
                    s_q.vbatt_below_rech && input_on;
  assign start_evt = allowed && no_block &&
                     ((phase_q == PH_IDLE && (recycle ||
                     (chg_toggle && chg_en))) || rech_evt);
  assign timer_rst = start_evt || chg_toggle || hiz_toggle;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chg_en_prev_q <= 1'b1;
      hiz_prev_q <= 1'b0;
    end else begin
      chg_en_prev_q <= chg_en;
      hiz_prev_q <= hiz;
    end
  end

  // Millisecond enable for the long precharge timer
  assign tick = tick_cnt_q == TICK_CYCLES - 1;
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // Precharge safety timer, cleared by cycle and toggle events
  assign pre_expire = (phase_q == PH_PRE) && (pre_cnt_q >= PRE_TICKS);
  always_ff @(posedge aclk) begin
    if (!aresetn || timer_rst) begin
      pre_cnt_q <= 32'h0000_0000;
    end else if (phase_q == PH_PRE && tick && pre_cnt_q < PRE_TICKS) begin
      pre_cnt_q <= pre_cnt_q + 32'h0000_0001;
    end
  end

  // Termination delay, restarted when current rises above hysteresis
  assign term_done = term_run_q && (term_cnt_q == TERM_CYCLES - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn || phase_q != PH_CV || !en_term || timer_rst) begin
      term_run_q <= 1'b0;
      term_cnt_q <= 32'h0000_0000;
    end else if (!term_run_q) begin
      term_run_q <= s_q.ichg_at_term;
      term_cnt_q <= 32'h0000_0000;
    end else if (s_q.ibatt_above_hys || term_done) begin
      term_run_q <= 1'b0;
    end else begin
      term_cnt_q <= term_cnt_q + 32'h0000_0001;
    end
  end

  // Charge phase sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= PH_IDLE;
    end else if (!allowed || s_q.vbatt_ovp || pre_expire) begin
      phase_q <= PH_IDLE;
    end else if (start_evt) begin
      phase_q <= s_q.vbatt_above_pre ? PH_FAST : PH_PRE;
    end else begin
      case (phase_q)
        PH_PRE: if (s_q.vbatt_above_pre) begin
          phase_q <= PH_FAST;
        end
        PH_FAST: if (s_q.vbatt_at_full) begin
          phase_q <= PH_CV;
        end
        PH_CV: if (term_done && !s_q.ibatt_above_hys) begin
          phase_q <= PH_DONE;
        end
        default: ;
      endcase
    end
  end

  // Sticky faults, a set beats a same-cycle clear
  assign fault_clr = (wr_go && wr_slot == 3'h6) ?
                     (wdata_q & {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                     {8{wstrb_q[1]}}, {8{wstrb_q[0]}}}) : 32'h0000_0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q <= 4'h0;
    end else begin
      fault_q[FLT_SAFETY] <= pre_expire || (fault_q[FLT_SAFETY] &&
          !fault_clr[FLT_SAFETY] && !recycle && !chg_toggle);
      fault_q[FLT_BOVP] <= (s_q.vbatt_ovp && allowed) ||
          (fault_q[FLT_BOVP] && !fault_clr[FLT_BOVP]);
      fault_q[FLT_INPUT] <= (in_q == IN_ON && !s_q.vin_good) ||
          (fault_q[FLT_INPUT] && !fault_clr[FLT_INPUT]);
      fault_q[FLT_THERM] <= s_q.tj_shutdown ||
          (fault_q[FLT_THERM] && !fault_clr[FLT_THERM]);
    end
  end

  // Supplement mode hysteresis
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supp_q <= 1'b0;
    end else if (s_q.vsys_below_30) begin
      supp_q <= 1'b1;
    end else if (s_q.vsys_above_20) begin
      supp_q <= 1'b0;
    end
  end

  // Current source demand, done keeps tapering only in mode one
  assign charging = allowed && !s_q.vbatt_ovp &&
                    (phase_q == PH_PRE || phase_q == PH_FAST ||
                    phase_q == PH_CV ||
                    (phase_q == PH_DONE && term_mode));

  // Registered drive to the analog switches and loops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive <= '0;
    end else begin
      drive.input_pass_switch <= input_on && !hiz &&
                                 !s_q.tj_shutdown;
      drive.battery_switch <= !s_q.tj_shutdown && !force_off &&
          (!s_q.vin_present || supp_q || charging);
      drive.charge_on <= charging;
      drive.precharge_mode <= phase_q == PH_PRE;
      drive.cv_mode <= phase_q == PH_CV || phase_q == PH_DONE;
      drive.charge_reduce <= (s_q.dpm_limit && s_q.vsys_at_min) ||
                             s_q.tj_at_reg;
      drive.supplement_mode <= supp_q;
      drive.prechg_sel <= cur_q[9:8];
      drive.fast_sel <= cur_q[4:0];
      drive.full_sel <= volt_q[7:2];
      drive.die_temp_regulation_limit <= therm_q[1:0];
    end
  end

  // Checks on the control behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence input_qualified_s;
    in_q == IN_WAIT ##1 in_q == IN_ON;
  endsequence
  input_qual_a: assert property (input_qualified_s |->
      $past(imm_cnt_q) == IMM_CYCLES - 1)
    else $error("input qualified before immunity time");
  input_window_a: assert property (!s_q.vin_good |=>
      !drive.input_pass_switch)
    else $error("input switch on outside window");
  pre_hold_a: assert property (phase_q == PH_PRE && !s_q.vbatt_above_pre
      |=> phase_q != PH_FAST)
    else $error("left precharge below threshold");
  pre_timeout_a: assert property (pre_expire |=>
      fault_q[FLT_SAFETY] && phase_q == PH_IDLE)
    else $error("precharge timeout not handled");
  term_off_a: assert property (!en_term && phase_q != PH_DONE
      |=> phase_q != PH_DONE)
    else $error("done marked with termination off");
  batt_ovp_a: assert property (s_q.vbatt_ovp |=>
      !drive.charge_on ##0 phase_q == PH_IDLE)
    else $error("charging continued during battery over-voltage");
  dpm_reduce_a: assert property (s_q.dpm_limit && s_q.vsys_at_min
      |=> drive.charge_reduce)
    else $error("charge not reduced at minimum system voltage");
  supp_mode_a: assert property (s_q.vsys_below_30 |=> supp_q ##1
      (supp_q || s_q.vsys_above_20 || $past(s_q.vsys_above_20)))
    else $error("supplement mode hysteresis wrong");
  discharge_a: assert property (!s_q.vin_present && !s_q.tj_shutdown &&
      !force_off |=> drive.battery_switch)
    else $error("battery switch off in discharge mode");
  therm_off_a: assert property (s_q.tj_shutdown |=>
      !drive.input_pass_switch && !drive.battery_switch)
    else $error("switches on at thermal shutdown");
endmodule // cpc_charge_phase_controller

// ==== cpc_analog_model.sv ====
// Analog side model: comparator flags fed back from switch controls
`timescale 1ns/1ps
module cpc_analog_model import cpc_pkg::*; (
  input wire cpc_sense_t stim,
  input wire cpc_drive_t drive,
  output cpc_sense_t sense_pins
);
  // Current only tapers to end-of-charge level while charging in CV
  always_comb begin
    sense_pins = stim;
    sense_pins.ichg_at_term = stim.ichg_at_term && drive.charge_on &&
      drive.cv_mode;
  end
endmodule // cpc_analog_model

// ==== tb_top.sv ====
// Testbench: register bus tasks and charge phase scenarios
`timescale 1ns/1ps
module tb_top import cpc_pkg::*;;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  cpc_sense_t stim, pins; // Bench levels, model outputs
  cpc_drive_t drv; // Design switch controls
  int fails, num_checks;
  cpc_charge_phase_controller #(.IMM_CYCLES(8), .TERM_CYCLES(10),
    .TICK_CYCLES(4), .PRE_TICKS(5)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sense_pins(pins),
    .drive(drv));
  cpc_analog_model model (.stim(stim), .drive(drv), .sense_pins(pins));
  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Write one word, keep response in r
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  // Read one word into d, response in r
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic ph(input logic [2:0] e);
    rd(REG_STATUS);
    chk("phase", {29'h0, e}, {29'h0, d[2:0]});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, well past the expected run
  initial begin
    settle(5000);
    fails++;
    conclude();
  end
  initial begin
    {fails, num_checks, aresetn, stim, awvalid, wvalid, bready} = '0;
    {arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    settle(4);
    aresetn <= 1'b1;
    rd(REG_CTRL);
    chk("ctrl", CTRL_RST, d);
    rd(8'h40);
    chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(REG_STATUS, 32'h7);
    chk("ro write", {30'h0, RESP_SLVERR}, {30'h0, r});
    $display("test registers done");
    stim.vin_present <= 1'b1;
    stim.vin_good <= 1'b1;
    settle(5);
    chk("early switch", 0, drv.input_pass_switch);
    settle(10);
    chk("in switch", 1, drv.input_pass_switch);
    chk("pre sel", 1, drv.prechg_sel);
    ph(PH_PRE);
    chk("qualified", 1, d[5]);
    chk("tj sel", 3, drv.die_temp_regulation_limit);
    settle(30);
    rd(REG_FAULT);
    chk("safety", 1, d[FLT_SAFETY]);
    ph(PH_IDLE);
    stim.vbatt_above_pre <= 1'b1;
    wr(REG_CTRL, 32'h0);
    wr(REG_CTRL, 32'h1);
    chk("ok resp", {30'h0, RESP_OKAY}, {30'h0, r});
    settle(4);
    ph(PH_FAST);
    chk("fast sel", 8, drv.fast_sel);
    rd(REG_FAULT);
    chk("fault clr", 0, d);
    stim.vbatt_at_full <= 1'b1;
    settle(5);
    ph(PH_CV);
    chk("full sel", 32'h20, drv.full_sel);
    wr(REG_TERM, 32'h0);
    stim.ichg_at_term <= 1'b1;
    settle(25);
    ph(PH_CV);
    wr(REG_TERM, TERM_RST);
    settle(20);
    ph(PH_DONE);
    chk("charge off", 0, drv.charge_on);
    stim.vbatt_at_full <= 1'b0;
    stim.ichg_at_term <= 1'b0;
    stim.vbatt_below_rech <= 1'b1;
    settle(6);
    ph(PH_FAST);
    $display("test charge cycle done");
    stim.vbatt_ovp <= 1'b1;
    settle(5);
    chk("ovp charge", 0, drv.charge_on);
    rd(REG_FAULT);
    chk("ovp fault", 1, d[FLT_BOVP]);
    stim.dpm_limit <= 1'b1;
    stim.vsys_at_min <= 1'b1;
    settle(5);
    chk("dpm reduce", 1, drv.charge_reduce);
    stim.dpm_limit <= 1'b0;
    stim.tj_at_reg <= 1'b1;
    settle(5);
    chk("tj reduce", 1, drv.charge_reduce);
    stim.vsys_below_30 <= 1'b1;
    settle(5);
    stim.vsys_below_30 <= 1'b0;
    settle(5);
    chk("supp held", 1, drv.supplement_mode);
    stim.vsys_above_20 <= 1'b1;
    settle(5);
    chk("supp off", 0, drv.supplement_mode);
    stim.vin_good <= 1'b0;
    settle(5);
    chk("window", 0, drv.input_pass_switch);
    stim.vin_present <= 1'b0;
    settle(5);
    chk("discharge", 1, drv.battery_switch);
    stim.tj_shutdown <= 1'b1;
    settle(5);
    chk("hot batt", 0, drv.battery_switch);
    $display("test power path done");
    conclude();
  end
endmodule // tb_top
